// >>> rtl/cubmf_pkg.sv
// Constants and types shared by the consumer user-bit message FIFO.
package cubmf_pkg;

    // --------------------------------------------------------------
    // Message format
    // --------------------------------------------------------------
    localparam int UNIT_LEN = 8;
    localparam int PAYLOAD_LEN = 7;
    localparam int MAX_FILL = 8;
    localparam int GAP_LEN = 9;
    localparam int MSG_MIN_UNITS = 3;
    localparam int MSG_MAX_UNITS = 129;
    localparam int FILL_W = 4;
    localparam logic [3:0] FILL_SAT = 4'h000F;

    // --------------------------------------------------------------
    // FIFO word layout: {input filler, last of message, payload}
    // --------------------------------------------------------------
    localparam int WORD_PAY_LSB = 0;
    localparam int WORD_LAST_BIT = 7;
    localparam int WORD_FILL_LSB = 8;
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 8;

    // --------------------------------------------------------------
    // Rate measurement and reset values
    // --------------------------------------------------------------
    localparam int RATIO_WIN_LOG = 8;
    localparam int Q_LEN = 96;
    localparam logic [3:0] MIN_FILL_RST = 4'h0008;

    typedef enum logic [1:0] {
        UB_ZEROS,
        UB_BLOCK,
        UB_SCALED,
        UB_MSGBUF
    } cubmf_mode_t;

    typedef enum logic {
        TX_FILL,
        TX_UNIT
    } cubmf_tx_t;

endpackage

// >>> rtl/cubmf_fifo.sv
// Synchronous word FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/1ns
module cubmf_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("cubmf_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_o = (count_ff != FULL_CNT);
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem[rd_ptr_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// >>> rtl/cubmf_top.sv
// User-bit retiming between input and output frame strobes for consumer-format messages.
`timescale 1ns/1ns
module cubmf_top #(
    parameter int DEPTH = cubmf_pkg::FIFO_DEPTH,
    parameter int RATIO_LOG = cubmf_pkg::RATIO_WIN_LOG,
    parameter int QLEN = cubmf_pkg::Q_LEN
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [1:0] mode_i,
    input wire logic in_frame_i,
    input wire logic in_ubit_i,
    input wire logic out_frame_i,
    output logic out_ubit_o,
    output logic [QLEN-1:0] q_subcode_o,
    output logic q_update_o,
    output logic [3:0] min_gap_len_o,
    input wire logic [1:0] ovw_clear_i,
    input wire logic [1:0] ovw_mask_i,
    output logic [1:0] ovw_flag_o,
    output logic ovw_event_o
);
    localparam int RW = RATIO_LOG + 3;
    localparam int PW = cubmf_pkg::FILL_W + 1 + RW;
    localparam logic [RW-1:0] RATIO_ONE = RW'(1 << RATIO_LOG);
    localparam logic [RATIO_LOG-1:0] WIN_LAST = '1;
    localparam logic [7:0] ZERO_SAT = 8'h00FF;

    initial begin
        if (RATIO_LOG < 2 || RATIO_LOG > 12 || QLEN < 1 || DEPTH < 2) begin
            $error("cubmf_top: parameter out of range");
        end
    end

    // ------------------------------------------------------------------
    // Mode register and flush control
    // ------------------------------------------------------------------
    cubmf_pkg::cubmf_mode_t mode_ff;
    logic mode_change;
    logic flush;
    logic ovw_hit;
    logic scaled;
    logic msgbuf;

    assign mode_change = (mode_i != mode_ff);
    assign scaled = (mode_ff == cubmf_pkg::UB_SCALED);
    assign msgbuf = (mode_ff == cubmf_pkg::UB_MSGBUF);
    assign flush = mode_change || (msgbuf && ovw_hit);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_ff <= cubmf_pkg::UB_ZEROS;
        end else if (mode_change) begin
            mode_ff <= cubmf_pkg::cubmf_mode_t'(mode_i);
        end
    end

    // ------------------------------------------------------------------
    // Input parser
    // ------------------------------------------------------------------
    logic in_unit_ff;
    logic [2:0] in_cnt_ff;
    logic [6:0] in_shift_ff;
    logic [3:0] zrun_ff;
    logic [3:0] cur_fill_ff;
    logic pend_valid_ff;
    logic [3:0] pend_fill_ff;
    logic [6:0] pend_pay_ff;
    logic [3:0] min_fill_ff;
    logic [QLEN-1:0] q_shift_ff;
    logic wr_valid;
    logic wr_last;
    logic wr_ready;
    logic [cubmf_pkg::WORD_W-1:0] wr_word;
    logic active;
    logic unit_done;
    logic unit_start;
    logic gap_seen;

    assign active = scaled || msgbuf;
    assign unit_start = in_frame_i && active && !in_unit_ff && in_ubit_i;
    assign unit_done = in_frame_i && in_unit_ff && (in_cnt_ff == 3'h0007);
    // A zero run reaching nine closes the message of the held unit
    assign gap_seen = in_frame_i && active && !in_unit_ff && !in_ubit_i
                      && (zrun_ff == 4'(cubmf_pkg::GAP_LEN - 1));
    // A held unit is written once its following filler is known
    // Scaled mode stores each unit as it completes, tagged with the filler before it
    assign wr_valid = scaled ? unit_done
                      : (pend_valid_ff && (gap_seen || (unit_start && zrun_ff <= 4'(cubmf_pkg::MAX_FILL))));
    assign wr_last = !scaled && gap_seen;
    assign wr_word = scaled ? {cur_fill_ff, 1'b0, in_shift_ff[5:0], in_ubit_i}
                     : {pend_fill_ff, wr_last, pend_pay_ff};
    assign ovw_hit = wr_valid && !wr_ready;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_unit_ff <= 1'b0;
            in_cnt_ff <= '0;
            in_shift_ff <= '0;
            zrun_ff <= cubmf_pkg::FILL_SAT;
            cur_fill_ff <= cubmf_pkg::FILL_SAT;
        end else if (mode_change) begin
            in_unit_ff <= 1'b0;
            in_cnt_ff <= '0;
            zrun_ff <= cubmf_pkg::FILL_SAT;
        end else if (in_frame_i && active) begin
            if (in_unit_ff) begin
                in_shift_ff <= {in_shift_ff[5:0], in_ubit_i};
                in_cnt_ff <= in_cnt_ff + 1'b1;
                if (unit_done) begin
                    in_unit_ff <= 1'b0;
                    zrun_ff <= '0;
                end
            end else if (in_ubit_i) begin
                in_unit_ff <= 1'b1;
                in_cnt_ff <= 3'h0001;
                cur_fill_ff <= zrun_ff;
            end else if (zrun_ff != cubmf_pkg::FILL_SAT) begin
                zrun_ff <= zrun_ff + 1'b1;
            end
        end
    end

    // Completed unit waits here until its message position is known
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_valid_ff <= 1'b0;
            pend_fill_ff <= '0;
            pend_pay_ff <= '0;
        end else if (mode_change) begin
            pend_valid_ff <= 1'b0;
        end else if (unit_done) begin
            pend_valid_ff <= 1'b1;
            pend_fill_ff <= cur_fill_ff;
            pend_pay_ff <= {in_shift_ff[5:0], in_ubit_i};
        end else if (wr_valid) begin
            pend_valid_ff <= 1'b0;
        end
    end

    // Shortest filler seen inside a message sets the message-mode spacing
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            min_fill_ff <= cubmf_pkg::MIN_FILL_RST;
        end else if (mode_change) begin
            min_fill_ff <= cubmf_pkg::MIN_FILL_RST;
        end else if (unit_start && zrun_ff < min_fill_ff) begin
            min_fill_ff <= zrun_ff;
        end
    end

    // Q bit is the first payload bit after the start marker
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_shift_ff <= '0;
            q_subcode_o <= '0;
            q_update_o <= 1'b0;
        end else begin
            q_update_o <= 1'b0;
            if (mode_change) begin
                q_shift_ff <= '0;
            end else if (gap_seen && pend_valid_ff) begin
                q_subcode_o <= q_shift_ff;
                q_update_o <= 1'b1;
                q_shift_ff <= '0;
            end else if (in_frame_i && in_unit_ff && in_cnt_ff == 3'h0001) begin
                q_shift_ff <= {q_shift_ff[QLEN-2:0], in_ubit_i};
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            min_gap_len_o <= cubmf_pkg::MIN_FILL_RST;
        end else begin
            min_gap_len_o <= min_fill_ff;
        end
    end

    // ------------------------------------------------------------------
    // FIFO between the two frame rates
    // ------------------------------------------------------------------
    logic rd_valid;
    logic rd_ready;
    logic [cubmf_pkg::WORD_W-1:0] rd_word;

    cubmf_fifo #(
        .WIDTH(cubmf_pkg::WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .flush_i(flush),
        .in_valid_i(wr_valid),
        .in_ready_o(wr_ready),
        .in_data_i(wr_word),
        .out_valid_o(rd_valid),
        .out_ready_i(rd_ready),
        .out_data_o(rd_word)
    );

    // Complete messages held, so message mode never starts a partial one
    logic [7:0] msg_cnt_ff;
    logic msg_in;
    logic msg_out;

    assign msg_in = wr_valid && wr_ready && wr_last;
    assign msg_out = rd_ready && rd_word[cubmf_pkg::WORD_LAST_BIT];

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            msg_cnt_ff <= '0;
        end else if (flush) begin
            msg_cnt_ff <= '0;
        end else if (msg_in && !msg_out) begin
            msg_cnt_ff <= msg_cnt_ff + 1'b1;
        end else if (msg_out && !msg_in) begin
            msg_cnt_ff <= msg_cnt_ff - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Rate ratio: output frames counted over a window of input frames
    // ------------------------------------------------------------------
    logic [RATIO_LOG-1:0] win_cnt_ff;
    logic [RW-1:0] out_acc_ff;
    logic [RW-1:0] ratio_ff;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            win_cnt_ff <= '0;
            out_acc_ff <= '0;
            ratio_ff <= RATIO_ONE;
        end else begin
            if (in_frame_i) begin
                win_cnt_ff <= win_cnt_ff + 1'b1;
            end
            if (in_frame_i && win_cnt_ff == WIN_LAST) begin
                ratio_ff <= out_acc_ff + RW'(out_frame_i);
                out_acc_ff <= '0;
            end else if (out_frame_i && out_acc_ff != '1) begin
                out_acc_ff <= out_acc_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output filler length for the head unit in scaled mode
    // ------------------------------------------------------------------
    logic [RATIO_LOG-1:0] frac_ff;
    logic [PW-1:0] prod;
    logic [PW-1:0] span;
    logic [7:0] gap_len;
    logic [7:0] need;

    always_comb begin
        prod = PW'({1'b0, rd_word[cubmf_pkg::WORD_FILL_LSB +: cubmf_pkg::FILL_W]} + 5'(cubmf_pkg::UNIT_LEN))
               * PW'(ratio_ff) + PW'(frac_ff);
        span = prod >> RATIO_LOG;
        // Negative result can only come with a full FIFO, flagged on write
        if (span > PW'(cubmf_pkg::UNIT_LEN)) begin
            gap_len = 8'(span - PW'(cubmf_pkg::UNIT_LEN));
        end else begin
            gap_len = '0;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    cubmf_pkg::cubmf_tx_t tx_state_ff;
    logic [2:0] tx_cnt_ff;
    logic [6:0] tx_shift_ff;
    logic [7:0] fill_cnt_ff;
    logic prev_last_ff;
    logic [1:0] ovw_set;

    always_comb begin
        if (scaled) begin
            need = gap_len;
        end else if (prev_last_ff) begin
            need = 8'(cubmf_pkg::GAP_LEN);
        end else begin
            need = 8'(min_fill_ff);
        end
    end

    // Filler is counted only while a head waits, which gives a message start its slack
    assign rd_ready = out_frame_i && active && (tx_state_ff == cubmf_pkg::TX_FILL) && rd_valid
                      && (fill_cnt_ff >= need) && (scaled || !prev_last_ff || msg_cnt_ff != '0);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_last_ff <= 1'b1;
        end else if (flush) begin
            prev_last_ff <= 1'b1;
        end else if (rd_ready) begin
            prev_last_ff <= !scaled && rd_word[cubmf_pkg::WORD_LAST_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fill_cnt_ff <= '0;
        end else if (flush || rd_ready) begin
            fill_cnt_ff <= '0;
        end else if (out_frame_i && rd_valid && tx_state_ff == cubmf_pkg::TX_FILL && fill_cnt_ff != ZERO_SAT) begin
            fill_cnt_ff <= fill_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frac_ff <= '0;
        end else if (flush) begin
            frac_ff <= '0;
        end else if (rd_ready && scaled) begin
            frac_ff <= prod[RATIO_LOG-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_state_ff <= cubmf_pkg::TX_FILL;
            tx_cnt_ff <= '0;
            tx_shift_ff <= '0;
            out_ubit_o <= 1'b0;
        end else if (mode_change) begin
            tx_state_ff <= cubmf_pkg::TX_FILL;
            out_ubit_o <= 1'b0;
        end else if (out_frame_i) begin
            case (tx_state_ff)
                cubmf_pkg::TX_FILL: begin
                    if (rd_ready) begin
                        out_ubit_o <= 1'b1;
                        tx_shift_ff <= rd_word[cubmf_pkg::WORD_PAY_LSB +: cubmf_pkg::PAYLOAD_LEN];
                        tx_cnt_ff <= '0;
                        tx_state_ff <= cubmf_pkg::TX_UNIT;
                    end else begin
                        out_ubit_o <= 1'b0;
                    end
                end
                cubmf_pkg::TX_UNIT: begin
                    out_ubit_o <= tx_shift_ff[6];
                    tx_shift_ff <= {tx_shift_ff[5:0], 1'b0};
                    tx_cnt_ff <= tx_cnt_ff + 1'b1;
                    if (tx_cnt_ff == 3'h6) begin
                        tx_state_ff <= cubmf_pkg::TX_FILL;
                    end
                end
                default: begin
                    tx_state_ff <= cubmf_pkg::TX_FILL;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Overwrite flags: bit 0 scaled mode, bit 1 message mode
    // ------------------------------------------------------------------
    assign ovw_set = {msgbuf && ovw_hit, scaled && ovw_hit};

    // A new overwrite wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovw_flag_o <= '0;
            ovw_event_o <= 1'b0;
        end else begin
            ovw_flag_o <= (ovw_flag_o & ~ovw_clear_i) | ovw_set;
            ovw_event_o <= |(ovw_set & ~ovw_mask_i);
        end
    end
endmodule

// >>> bench/cubmf_props.sv
// Port-level assertions for the consumer user-bit retimer.
`timescale 1ns/1ns
module cubmf_props (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [1:0] mode_i,
    input wire logic out_frame_i,
    input wire logic out_ubit_o,
    input wire logic q_update_o,
    input wire logic [3:0] min_gap_len_o,
    input wire logic [1:0] ovw_clear_i,
    input wire logic [1:0] ovw_mask_i,
    input wire logic [1:0] ovw_flag_o,
    input wire logic ovw_event_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Cycles since the last output frame strobe, saturating
    logic [3:0] since_ff;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            since_ff <= 4'hF;
        end else if (out_frame_i) begin
            since_ff <= 4'h0;
        end else if (since_ff != 4'hF) begin
            since_ff <= since_ff + 4'h1;
        end
    end
    sequence s_zeros;
        (mode_i == cubmf_pkg::UB_ZEROS) [*4];
    endsequence
    sequence s_steady;
        $stable(mode_i) [*3];
    endsequence
    sequence s_clear;
        (ovw_clear_i == 2'h3) [*2];
    endsequence
    sequence s_masked;
        (ovw_mask_i == 2'h3) [*2];
    endsequence
    property p_zeros_out;
        s_zeros |-> !out_ubit_o;
    endproperty
    property p_zeros_quiet;
        s_zeros |-> !ovw_event_o;
    endproperty
    property p_gap_start;
        $rose(resetn_i) |-> min_gap_len_o == cubmf_pkg::MIN_FILL_RST;
    endproperty
    property p_gap_max;
        min_gap_len_o <= 4'h8;
    endproperty
    property p_gap_shrink;
        s_steady |-> min_gap_len_o <= $past(min_gap_len_o);
    endproperty
    property p_clear;
        s_clear |-> ovw_flag_o == 2'h0;
    endproperty
    property p_mask;
        s_masked |-> !ovw_event_o;
    endproperty
    property p_q_pulse;
        q_update_o |=> !q_update_o;
    endproperty
    // A mid-frame change is tolerated only around a mode change or an overwrite event
    property p_out_frame;
        $changed(out_ubit_o) && $stable(mode_i) && (mode_i == $past(mode_i, 2)) && !ovw_event_o
            && !$past(ovw_event_o) |-> since_ff <= 4'h3;
    endproperty
    a_zeros_out: assert property (p_zeros_out) else $error("output not zero in zeros mode");
    a_zeros_quiet: assert property (p_zeros_quiet) else $error("overwrite event in zeros mode");
    a_gap_start: assert property (p_gap_start) else $error("shortest gap not at start value");
    a_gap_max: assert property (p_gap_max) else $error("shortest gap above eight");
    a_gap_shrink: assert property (p_gap_shrink) else $error("shortest gap grew");
    a_clear: assert property (p_clear) else $error("overwrite flag survived clear");
    a_mask: assert property (p_mask) else $error("masked overwrite raised event");
    a_q_pulse: assert property (p_q_pulse) else $error("q update longer than one cycle");
    a_out_frame: assert property (p_out_frame) else $error("output bit moved outside frame");
endmodule

// >>> bench/cubmf_far.sv
// Far-side model: upstream user-bit source and downstream frame sampler.
`timescale 1ns/1ns
module cubmf_far (
    input wire logic clock_i,
    output logic in_frame_o,
    output logic in_ubit_o,
    output logic out_frame_o,
    input wire logic out_ubit_i
);
    int in_per = 8;
    int out_per = 8;
    int in_cnt = 0;
    int out_cnt = 0;
    logic tx_q[$];
    logic rx_q[$];
    initial begin
        in_frame_o = 1'b0;
        in_ubit_o = 1'b0;
        out_frame_o = 1'b0;
    end
    // Data only counts in its frame slot, so it toggles elsewhere to expose bad sampling
    always @(negedge clock_i) begin
        in_cnt++;
        out_cnt++;
        if (in_cnt >= in_per) begin
            in_cnt = 0;
            in_frame_o <= 1'b1;
            in_ubit_o <= (tx_q.size() > 0) ? tx_q.pop_front() : 1'b0;
        end else begin
            in_frame_o <= 1'b0;
            in_ubit_o <= ~in_ubit_o;
        end
        if (out_cnt >= out_per) begin
            out_cnt = 0;
            rx_q.push_back(out_ubit_i);
        end
        out_frame_o <= (out_cnt == 0);
    end
endmodule

// >>> bench/cubmf_top_test.sv
// Self-checking bench for the consumer user-bit retimer.
`timescale 1ns/1ns
module cubmf_top_test;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic [1:0] ovw_clear_i = 2'h0;
    logic [1:0] ovw_mask_i = 2'h0;
    logic in_frame, in_ubit, out_frame, out_ubit, q_update, ovw_event;
    logic [cubmf_pkg::Q_LEN-1:0] q_subcode;
    logic [3:0] min_gap;
    logic [1:0] ovw_flag;
    int n_mismatch = 0;
    int checked = 0;
    int ev_seen = 0;
    int q_seen = 0;
    logic [7:0] sent_q[$];
    logic [7:0] units_q[$];
    int gaps_q[$];
    always #2 clock_i = ~clock_i;
    always @(negedge clock_i) begin
        if (ovw_event === 1'b1) ev_seen++;
        if (q_update === 1'b1) q_seen++;
    end
    // Short rate window keeps the ratio estimate settling quickly
    cubmf_top #(.RATIO_LOG(4)) dut (.clock_i(clock_i), .resetn_i(resetn_i), .mode_i(mode_i),
        .in_frame_i(in_frame), .in_ubit_i(in_ubit), .out_frame_i(out_frame), .out_ubit_o(out_ubit),
        .q_subcode_o(q_subcode), .q_update_o(q_update), .min_gap_len_o(min_gap),
        .ovw_clear_i(ovw_clear_i), .ovw_mask_i(ovw_mask_i), .ovw_flag_o(ovw_flag), .ovw_event_o(ovw_event));
    cubmf_far far (.clock_i(clock_i), .in_frame_o(in_frame), .in_ubit_o(in_ubit),
        .out_frame_o(out_frame), .out_ubit_i(out_ubit));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic start(input logic [1:0] m, input int ip, input int op);
        @(negedge clock_i);
        resetn_i = 1'b0;
        mode_i = m;
        far.in_per = ip;
        far.out_per = op;
        far.tx_q.delete();
        repeat (12) @(negedge clock_i);
        resetn_i = 1'b1;
        far.rx_q.delete();
    endtask
    task automatic send(input int n, input int fill);
        logic [7:0] u;
        sent_q.delete();
        for (int k = 0; k < n; k++) begin
            u = {1'b1, 7'(k * 37 + 5)};
            sent_q.push_back(u);
            repeat (k > 0 ? fill : 0) far.tx_q.push_back(1'b0);
            for (int b = 7; b >= 0; b--) far.tx_q.push_back(u[b]);
        end
        repeat (40) far.tx_q.push_back(1'b0);
    endtask
    task automatic drain(input int cyc);
        for (int t = 0; t < 20000 && far.tx_q.size() > 0; t++) @(negedge clock_i);
        repeat (cyc) @(negedge clock_i);
    endtask
    function automatic int ones();
        int c;
        c = 0;
        foreach (far.rx_q[i]) if (far.rx_q[i] === 1'b1) c++;
        return c;
    endfunction
    task automatic check_msg(input int gap);
        int z;
        int i;
        logic [7:0] u;
        z = 0;
        i = 0;
        units_q.delete();
        gaps_q.delete();
        while (i < far.rx_q.size()) begin
            if (far.rx_q[i] === 1'b1 && i + 8 <= far.rx_q.size()) begin
                if (units_q.size() > 0) gaps_q.push_back(z);
                for (int b = 0; b < 8; b++) u = {u[6:0], far.rx_q[i + b]};
                units_q.push_back(u);
                i += 8;
                z = 0;
            end else begin
                z++;
                i++;
            end
        end
        chk("unit count", 32'(units_q.size()), 32'(sent_q.size()));
        foreach (units_q[k]) if (k < sent_q.size()) chk("unit", 32'(units_q[k]), 32'(sent_q[k]));
        foreach (gaps_q[k]) if (k + 1 < sent_q.size()) chk("gap", 32'(gaps_q[k]), 32'(gap));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_zeros();
        start(cubmf_pkg::UB_ZEROS, 8, 8);
        send(3, 2);
        drain(400);
        chk("ones in zeros mode", 32'(ones()), 32'h0);
        $display("test zeros done");
    endtask
    task automatic t_msgbuf();
        start(cubmf_pkg::UB_MSGBUF, 8, 8);
        q_seen = 0;
        send(4, 3);
        for (int t = 0; t < 20000 && far.tx_q.size() > 40; t++) @(negedge clock_i);
        chk("ones before message end", 32'(ones()), 32'h0);
        drain(800);
        check_msg(3);
        chk("shortest gap", 32'(min_gap), 32'h3);
        chk("q updates", 32'(q_seen > 0), 32'h1);
        $display("test message mode done");
    endtask
    task automatic t_scaled();
        // Rates chosen so the ratio window holds a whole number of output frames
        int ip[3] = '{8, 6, 12};
        int op[3] = '{8, 8, 8};
        int fl[3] = '{3, 4, 0};
        int og[3] = '{3, 1, 4};
        for (int k = 0; k < 3; k++) begin
            start(cubmf_pkg::UB_SCALED, ip[k], op[k]);
            repeat (64) far.tx_q.push_back(1'b0);
            send(4, fl[k]);
            drain(1500);
            check_msg(og[k]);
        end
        $display("test scaled mode done");
    endtask
    task automatic t_ovw();
        for (int k = 0; k < 2; k++) begin
            start(k ? cubmf_pkg::UB_MSGBUF : cubmf_pkg::UB_SCALED, 4, 16);
            ev_seen = 0;
            send(24, 0);
            drain(100);
            chk("overwrite flag", 32'(|ovw_flag), 32'h1);
            chk("overwrite event", 32'(ev_seen > 0), 32'h1);
            ovw_clear_i = 2'h3;
            repeat (3) @(negedge clock_i);
            ovw_clear_i = 2'h0;
            chk("flag after clear", 32'(ovw_flag), 32'h0);
            ovw_mask_i = 2'h3;
            ev_seen = 0;
            send(24, 0);
            drain(100);
            chk("masked event", 32'(ev_seen), 32'h0);
            ovw_mask_i = 2'h0;
        end
        $display("test overwrite done");
    endtask
    task automatic t_mode();
        start(cubmf_pkg::UB_MSGBUF, 4, 16);
        send(4, 0);
        for (int t = 0; t < 20000 && far.tx_q.size() > 30; t++) @(negedge clock_i);
        mode_i = cubmf_pkg::UB_ZEROS;
        repeat (20) @(negedge clock_i);
        mode_i = cubmf_pkg::UB_MSGBUF;
        far.rx_q.delete();
        drain(1500);
        chk("ones after mode change", 32'(ones()), 32'h0);
        $display("test mode change done");
    endtask
    initial begin
        t_zeros();
        t_msgbuf();
        t_scaled();
        t_ovw();
        t_mode();
        close_out();
    end
    // Whole run needs about 20000 cycles; three times that means a hang
    initial begin
        #(4 * 60000);
        n_mismatch++;
        $display("watchdog expired");
        close_out();
    end
endmodule
bind cubmf_top cubmf_props u_props (.clock_i(clock_i), .resetn_i(resetn_i), .mode_i(mode_i),
    .out_frame_i(out_frame_i), .out_ubit_o(out_ubit_o), .q_update_o(q_update_o),
    .min_gap_len_o(min_gap_len_o), .ovw_clear_i(ovw_clear_i), .ovw_mask_i(ovw_mask_i),
    .ovw_flag_o(ovw_flag_o), .ovw_event_o(ovw_event_o));
